// ---- inc/tx_fifo_regs.svh ----
// register offsets, field positions and reset values of the transmit queue front end
// assumes an 8-bit in-port byte address; port select is decoded outside
`ifndef TX_FIFO_REGS_SVH
`define TX_FIFO_REGS_SVH

`define OFS_CTRL        8'hA0
`define OFS_DATA        8'hA2
`define OFS_STAT        8'hA4
`define OFS_LATCH       8'hA6
`define OFS_IEN         8'hA8

`define CTRL_RST        16'h0800
`define CTRL_MASK       16'h1F09
`define CTRL_THR_LSB    8
`define CTRL_THR_W      5
`define CTRL_MSB_BIT    3
`define CTRL_FLUSH_BIT  0

`define DATA_VAL_LSB    8
`define DATA_MARK_BIT   0

`define STAT_GRP_LSB    8
`define STAT_GRP_W      6
`define GROUP_SHIFT     3

`define BIT_OVF         5
`define BIT_UDF         4
`define BIT_PKT         3
`define BIT_FULL        2
`define BIT_EMPTY       1
`define BIT_SPACE       0

`define EVT_MASK        16'h003F
`define LATCH_RST       16'h0000
`define IEN_RST         16'h0000

`endif

// ---- inc/tx_fifo_pkg.sv ----
// types shared by the transmit queue front end and its storage
// assumes nothing beyond a SystemVerilog compiler
package tx_fifo_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [1:0]  be;
      logic        wr;
      logic        rd;
   } bus_req_t;

   typedef struct packed {
      logic       mark;
      logic [7:0] value;
   } q_entry_t;

   typedef struct packed {
      logic value;
      logic valid;
      logic last;
   } ser_out_t;

   typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_t;

endpackage

// ---- src/tx_byte_store.sv ----
// flip-flop queue storage with fill count
// assumes the caller never pushes when full nor pops when empty; DEPTH is a power of two
`timescale 1ns/100ps
`default_nettype none

module tx_byte_store #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 256
) (
   // clock and control
   input  wire logic                       clk,
   input  wire logic                       srst,
   input  wire logic                       ce,
   input  wire logic                       clear,
   // fill side
   input  wire logic                       push,
   input  wire logic [WIDTH-1:0]           pushData,
   // drain side
   input  wire logic                       pop,
   output logic      [WIDTH-1:0]           popData,
   output logic      [$clog2(DEPTH):0]     count
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wrPtr_ff;
   logic [AW-1:0]    rdPtr_ff;
   logic [AW:0]      count_ff;

   assign popData = mem_ff[rdPtr_ff];
   assign count   = count_ff;

   // storage carries no reset: cheaper, and the count guards stale words
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem_ff[wrPtr_ff] <= pushData;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else if (ce) begin
         if (clear) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
         end else begin
            if (push) begin
               wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (pop) begin
               rdPtr_ff <= rdPtr_ff + 1'b1;
            end
            case ({push, pop})
               2'b10: count_ff <= count_ff + 1'b1;
               2'b01: count_ff <= count_ff - 1'b1;
               default: count_ff <= count_ff;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ---- src/hdlc_tx_queue.sv ----
// transmit queue front end: register port, byte queue, status, latched events, bit serialiser
// assumes a 16-bit host port with byte enables and a bit consumer that pulls one bit per cycle
// Behaviour
// - upper-byte data write pushes byte and mark
// - data register always reads as zero
// - bit 0 first, or bit 7 when reordered
// - mark bit tags last byte of packet
// - status shows free eight-byte groups
// - full flag set only at full depth
// - empty flag set when queue holds nothing
// - space flag when free bytes reach threshold
// - write into full queue latches overflow
// - running dry mid-packet latches underflow
// - reading a marked byte latches packet end
// - empty rise or flush release latches empty
// - space rise or flush release latches space
// - enables gate latched bits with port enable
// - full interrupt fed by full-rise latch
// - interrupt enables reset to zero
// - threshold is level times eight plus one
// - flush empties, halts, ignores data writes
`timescale 1ns/100ps
`default_nettype none

`include "tx_fifo_regs.svh"

module hdlc_tx_queue #(
   parameter int DEPTH = 256
) (
   // clock, enable, reset
   input  wire logic                  clk,
   input  wire logic                  ce,
   input  wire logic                  srst,
   // host register port
   input  wire tx_fifo_pkg::bus_req_t busReq,
   output logic      [15:0]           rdData,
   // packet processor bit pull
   input  wire logic                  bitReady,
   output var tx_fifo_pkg::ser_out_t  serOut,
   // interrupt
   input  wire logic                  portIrqEnable,
   output logic                       txIrq
);

   import tx_fifo_pkg::*;

   localparam int CW = $clog2(DEPTH) + 1;

   logic [15:0]   ctrl_ff;
   logic [15:0]   latch_ff;
   logic [15:0]   ien_ff;
   logic [15:0]   rdData_ff;
   logic          flushPrev_ff;
   logic          fullPrev_ff;
   logic          emptyPrev_ff;
   logic          spacePrev_ff;
   ser_state_t    state_ff;
   logic [7:0]    shift_ff;
   logic [2:0]    bitCnt_ff;
   logic          curEnd_ff;
   logic [CW-1:0] fillCount;
   q_entry_t      popEntry;
   q_entry_t      pushEntry;

   // address decode and byte lanes
   wire hitCtrl  = busReq.addr == `OFS_CTRL;
   wire hitData  = busReq.addr == `OFS_DATA;
   wire hitStat  = busReq.addr == `OFS_STAT;
   wire hitLatch = busReq.addr == `OFS_LATCH;
   wire hitIen   = busReq.addr == `OFS_IEN;
   wire wrHi     = busReq.wr & busReq.be[1];
   wire [15:0] laneMask = {{8{busReq.be[1]}}, {8{busReq.be[0]}}};
   wire [15:0] wrBits   = busReq.wdata & laneMask;

   // control fields
   wire                     flush    = ctrl_ff[`CTRL_FLUSH_BIT];
   wire                     msbFirst = ctrl_ff[`CTRL_MSB_BIT];
   wire [`CTRL_THR_W-1:0]   thrLevel = ctrl_ff[`CTRL_THR_LSB +: `CTRL_THR_W];

   // live queue flags
   wire          full       = fillCount == CW'(DEPTH);
   wire          empty      = fillCount == '0;
   wire [CW-1:0] freeBytes  = CW'(DEPTH) - fillCount;
   wire [`STAT_GRP_W-1:0] freeGroups = `STAT_GRP_W'(freeBytes >> `GROUP_SHIFT);
   wire [CW-1:0] thrBytes   = CW'({thrLevel, 3'h0}) + CW'(1);
   wire          spaceOk    = freeBytes >= thrBytes;

   // host writes into the queue; a flushed queue swallows them silently
   wire dataWr = busReq.wr & hitData & wrHi & ~flush;
   wire push   = dataWr & ~full;
   wire ovfEvt = dataWr & full;

   assign pushEntry.value = busReq.wdata[`DATA_VAL_LSB +: 8];
   assign pushEntry.mark  = busReq.wdata[`DATA_MARK_BIT];

   // serialiser fetches a byte when idle or as the last bit leaves
   wire bitTake  = (state_ff == SER_SHIFT) & bitReady;
   wire lastBit  = bitCnt_ff == 3'h7;
   wire needByte = (state_ff == SER_IDLE) | (bitTake & lastBit);
   wire pop      = needByte & ~empty & ~flush;
   wire udfEvt   = bitTake & lastBit & empty & ~curEnd_ff & ~flush;
   wire pktEvt   = pop & popEntry.mark;
   wire [7:0] revByte  = {<<{popEntry.value}};
   wire [7:0] loadByte = msbFirst ? revByte : popEntry.value;

   // edge sources for the latched register
   wire flushRel  = flushPrev_ff & ~flush;
   wire fullRise  = full & ~fullPrev_ff;
   wire emptyRise = (empty & ~emptyPrev_ff) | flushRel;
   wire spaceRise = (spaceOk & ~spacePrev_ff) | flushRel;

   wire [15:0] evtSet = {10'h000, ovfEvt, udfEvt, pktEvt, fullRise, emptyRise, spaceRise};
   wire [15:0] clrMask = (busReq.wr & hitLatch) ? (wrBits & `EVT_MASK) : 16'h0000;
   // set wins over a clear landing in the same cycle
   wire [15:0] nxt_latch = (latch_ff & ~clrMask) | evtSet;
   wire [15:0] nxt_ctrl  = (ctrl_ff & ~laneMask) | (wrBits & `CTRL_MASK);
   wire [15:0] nxt_ien   = (ien_ff & ~laneMask) | (wrBits & `EVT_MASK);

   // read selection; the data register has no read path at all
   wire [15:0] statusLive = {2'b00, freeGroups, 5'b00000, full, empty, spaceOk};
   wire [15:0] rdSel = hitCtrl  ? ctrl_ff :
                       hitStat  ? statusLive :
                       hitLatch ? latch_ff :
                       hitIen   ? ien_ff : 16'h0000;

   tx_byte_store #(
      .WIDTH ($bits(q_entry_t)),
      .DEPTH (DEPTH)
   ) u_store (
      .clk      (clk),
      .srst     (srst),
      .ce       (ce),
      .clear    (flush),
      .push     (push),
      .pushData (pushEntry),
      .pop      (pop),
      .popData  (popEntry),
      .count    (fillCount)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_ff <= `CTRL_RST;
         ien_ff  <= `IEN_RST;
      end else if (ce && busReq.wr) begin
         if (hitCtrl) begin
            ctrl_ff <= nxt_ctrl;
         end
         if (hitIen) begin
            ien_ff <= nxt_ien;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         latch_ff <= `LATCH_RST;
      end else if (ce) begin
         latch_ff <= nxt_latch;
      end
   end

   // previous flags start at their reset-time levels so nothing latches spuriously
   always_ff @(posedge clk) begin
      if (srst) begin
         flushPrev_ff <= 1'b0;
         fullPrev_ff  <= 1'b0;
         emptyPrev_ff <= 1'b1;
         spacePrev_ff <= 1'b1;
      end else if (ce) begin
         flushPrev_ff <= flush;
         fullPrev_ff  <= full;
         emptyPrev_ff <= empty;
         spacePrev_ff <= spaceOk;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdData_ff <= 16'h0000;
      end else if (ce && busReq.rd) begin
         rdData_ff <= rdSel;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff  <= SER_IDLE;
         shift_ff  <= 8'h00;
         bitCnt_ff <= 3'h0;
         curEnd_ff <= 1'b0;
      end else if (ce) begin
         case (state_ff)
            SER_IDLE, SER_SHIFT: begin
               if (flush) begin
                  // a partly sent byte is dropped, so the next fetch starts clean
                  state_ff  <= SER_IDLE;
                  bitCnt_ff <= 3'h0;
                  curEnd_ff <= 1'b0;
               end else if (pop) begin
                  state_ff  <= SER_SHIFT;
                  shift_ff  <= loadByte;
                  bitCnt_ff <= 3'h0;
                  curEnd_ff <= popEntry.mark;
               end else if (bitTake) begin
                  state_ff  <= lastBit ? SER_IDLE : SER_SHIFT;
                  shift_ff  <= {1'b0, shift_ff[7:1]};
                  bitCnt_ff <= bitCnt_ff + 3'h1;
               end
            end
            default: state_ff <= SER_IDLE;
         endcase
      end
   end

   assign rdData       = rdData_ff;
   assign serOut.value = shift_ff[0];
   assign serOut.valid = state_ff == SER_SHIFT;
   assign serOut.last  = (state_ff == SER_SHIFT) & curEnd_ff & lastBit;
   // one port-level enable gates every source
   assign txIrq = portIrqEnable & (|(latch_ff & ien_ff & `EVT_MASK));

   a_upper_push: assert property (
      @(posedge clk) disable iff (srst)
      (ce && busReq.wr && busReq.be[1] && hitData && !flush && !full && !pop)
      |=> fillCount == $past(fillCount) + CW'(1))
      else $error("upper data write did not push");

   a_lower_nopush: assert property (
      @(posedge clk) disable iff (srst)
      (ce && busReq.wr && !busReq.be[1] && !pop && !flush)
      |=> fillCount == $past(fillCount))
      else $error("lower byte write changed fill");

   a_data_readzero: assert property (
      @(posedge clk) disable iff (srst)
      (ce && busReq.rd && hitData) |=> rdData == 16'h0000)
      else $error("data register read not zero");

   a_first_bit: assert property (
      @(posedge clk) disable iff (srst)
      (ce && pop)
      |=> serOut.valid && serOut.value == ($past(msbFirst) ? $past(popEntry.value[7]) : $past(popEntry.value[0])))
      else $error("wrong first bit order");

   a_group_read: assert property (
      @(posedge clk) disable iff (srst)
      (ce && busReq.rd && hitStat)
      |=> rdData[13:8] == `STAT_GRP_W'((CW'(DEPTH) - $past(fillCount)) >> 3))
      else $error("free group count wrong");

   a_full_empty: assert property (
      @(posedge clk) disable iff (srst)
      (fillCount == CW'(DEPTH)) |-> statusLive[2] && !statusLive[1] && !spaceOk)
      else $error("full flags inconsistent");

   a_space_thr: assert property (
      @(posedge clk) disable iff (srst)
      (fillCount <= CW'(DEPTH) - CW'({thrLevel, 3'h0}) - CW'(1)) |-> statusLive[0])
      else $error("space flag low with room");

   a_ovf_latch: assert property (
      @(posedge clk) disable iff (srst)
      (ce && busReq.wr && busReq.be[1] && hitData && full && !flush)
      |=> latch_ff[`BIT_OVF] && fillCount == $past(fillCount) - CW'($past(pop)))
      else $error("overflow not latched");

   a_udf_latch: assert property (
      @(posedge clk) disable iff (srst)
      (ce && udfEvt) |=> latch_ff[`BIT_UDF] && !serOut.valid)
      else $error("underflow not latched");

   a_pkt_latch: assert property (
      @(posedge clk) disable iff (srst)
      (ce && pop && popEntry.mark) |=> latch_ff[`BIT_PKT])
      else $error("packet end not latched");

   a_flush_release: assert property (
      @(posedge clk) disable iff (srst)
      (ce && flushPrev_ff && !flush) |=> latch_ff[`BIT_EMPTY] && latch_ff[`BIT_SPACE])
      else $error("flush release not latched");

   a_irq_gate: assert property (
      @(posedge clk) disable iff (srst)
      !portIrqEnable || (latch_ff & ien_ff) == 16'h0000 |-> !txIrq)
      else $error("interrupt not gated");

   a_ien_reset: assert property (
      @(posedge clk)
      $fell(srst) |-> ien_ff == 16'h0000 && !txIrq)
      else $error("enables not cleared by reset");

   a_flush_ignore: assert property (
      @(posedge clk) disable iff (srst)
      (ce && flush) |=> fillCount == '0 && !serOut.valid)
      else $error("flush did not empty queue");

   a_w1c_clear: assert property (
      @(posedge clk) disable iff (srst)
      (ce && busReq.wr && hitLatch && busReq.be[0] && busReq.wdata[5] && !ovfEvt)
      |=> !latch_ff[`BIT_OVF])
      else $error("write one did not clear");

endmodule

`default_nettype wire

// ---- verification/bit_sink.sv ----
// packet processor stand-in: pulls serial bits and rebuilds bytes as they arrive
// assumes the queue presents one bit per cycle; stall holds bitReady low to act slow
`timescale 1ns/100ps
`default_nettype none

module bit_sink
   import tx_fifo_pkg::*;
(
   // clock and reset
   input  wire logic      clk,
   input  wire logic      srst,
   // serial side
   input  wire logic      stall,
   input  wire ser_out_t  serOut,
   output logic           bitReady,
   // rebuilt bytes, first bit lands in bit 0
   output logic [7:0]     gotByte,
   output logic           gotLast,
   output logic [7:0]     nBytes
);
   logic [7:0] shift_ff;
   logic [2:0] nBits_ff;
   wire        take = serOut.valid && bitReady;

   assign bitReady = !stall;

   always_ff @(posedge clk) begin
      if (srst) begin
         shift_ff <= 8'h00;
         nBits_ff <= 3'h0;
         gotByte  <= 8'h00;
         gotLast  <= 1'b0;
         nBytes   <= 8'h00;
      end else if (take) begin
         shift_ff <= {serOut.value, shift_ff[7:1]};
         nBits_ff <= nBits_ff + 3'h1;
         if (nBits_ff == 3'h7) begin
            gotByte <= {serOut.value, shift_ff[7:1]};
            gotLast <= serOut.last;
            nBytes  <= nBytes + 8'h01;
         end
      end
   end
endmodule

`default_nettype wire

// ---- verification/tb_hdlc_tx_queue.sv ----
// self-checking bench for the transmit queue front end
// assumes bit_sink as packet processor; only upper-lane data writes push
`timescale 1ns/100ps
`default_nettype none
`include "tx_fifo_regs.svh"

module tb_hdlc_tx_queue;
   import tx_fifo_pkg::*;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        ce = 1'b1;
   logic        stall = 1'b0;
   logic        portIrqEnable = 1'b0;
   bus_req_t    busReq = '0;
   logic [15:0] rdData;
   logic        bitReady;
   ser_out_t    serOut;
   logic        txIrq;
   logic [7:0]  gotByte;
   logic        gotLast;
   logic [7:0]  nBytes;
   int          errors = 0;
   int          checks_done = 0;

   always #50 clk = ~clk;

   hdlc_tx_queue #(.DEPTH(256)) u_dut (.clk(clk), .ce(ce), .srst(srst), .busReq(busReq),
      .rdData(rdData), .bitReady(bitReady), .serOut(serOut), .portIrqEnable(portIrqEnable),
      .txIrq(txIrq));

   bit_sink u_sink (.clk(clk), .srst(srst), .stall(stall), .serOut(serOut), .bitReady(bitReady),
      .gotByte(gotByte), .gotLast(gotLast), .nBytes(nBytes));

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask

   // read data stands until the next read, so one spare edge is safe
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      busReq.addr <= a;
      busReq.rd   <= 1'b1;
      @(posedge clk);
      busReq.rd <= 1'b0;
      @(posedge clk);
      #1;
      check(rdData, exp);
   endtask

   task automatic waitBytes(input logic [7:0] n);
      int i;
      // look after the edge has settled, never in the step that launches a byte
      for (i = 0; i < 200 && nBytes !== n; i++) begin
         @(posedge clk);
         #1;
      end
      if (nBytes !== n) begin
         check({8'h00, nBytes}, {8'h00, n});
         summarize();
      end
   endtask

   initial begin
      int k;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rdchk(`OFS_IEN, 16'h0000);
      rdchk(`OFS_CTRL, 16'h0800);
      rdchk(`OFS_STAT, 16'h2003);
      wr(`OFS_DATA, 2'b01, 16'h0001);
      rdchk(`OFS_STAT, 16'h2003);
      rdchk(`OFS_DATA, 16'h0000);
      // a frozen clock enable must swallow a full data write
      @(posedge clk);
      ce <= 1'b0;
      wr(`OFS_DATA, 2'b11, 16'h5501);
      ce <= 1'b1;
      rdchk(`OFS_STAT, 16'h2003);
      $display("test reset done");

      wr(`OFS_DATA, 2'b11, 16'hA501);
      rdchk(`OFS_DATA, 16'h0000);
      waitBytes(8'h01);
      check({8'h00, gotByte}, 16'h00A5);
      check({15'h0, gotLast}, 16'h0001);
      rdchk(`OFS_LATCH, 16'h000A);
      wr(`OFS_LATCH, 2'b11, 16'h003F);
      rdchk(`OFS_LATCH, 16'h0000);
      $display("test lsb first done");

      wr(`OFS_CTRL, 2'b11, 16'h0808);
      wr(`OFS_DATA, 2'b11, 16'h0100);
      waitBytes(8'h02);
      check({8'h00, gotByte}, 16'h0080);
      check({15'h0, gotLast}, 16'h0000);
      rdchk(`OFS_LATCH, 16'h0012);
      wr(`OFS_IEN, 2'b11, 16'h0010);
      #1;
      check({15'h0, txIrq}, 16'h0000);
      @(posedge clk);
      portIrqEnable <= 1'b1;
      @(posedge clk);
      #1;
      check({15'h0, txIrq}, 16'h0001);
      rdchk(`OFS_IEN, 16'h0010);
      wr(`OFS_LATCH, 2'b11, 16'h0010);
      #1;
      check({15'h0, txIrq}, 16'h0000);
      $display("test msb first done");

      // one byte sits in the stalled serialiser, so 257 writes fill the queue
      @(posedge clk);
      stall <= 1'b1;
      wr(`OFS_LATCH, 2'b11, 16'h003F);
      wr(`OFS_CTRL, 2'b11, 16'h1F08);
      for (k = 0; k < 8; k++)
         wr(`OFS_DATA, 2'b10, 16'h3C00);
      rdchk(`OFS_STAT, 16'h1F01);
      wr(`OFS_DATA, 2'b10, 16'h3C00);
      rdchk(`OFS_STAT, 16'h1F00);
      for (k = 0; k < 248; k++)
         wr(`OFS_DATA, 2'b10, 16'h3C00);
      rdchk(`OFS_STAT, 16'h0004);
      wr(`OFS_DATA, 2'b10, 16'h3C00);
      rdchk(`OFS_LATCH, 16'h0026);
      $display("test fill done");

      wr(`OFS_CTRL, 2'b11, 16'h1F09);
      wr(`OFS_DATA, 2'b11, 16'h7701);
      rdchk(`OFS_STAT, 16'h2003);
      // clear while still flushed, so only the release can set the two bits
      wr(`OFS_LATCH, 2'b11, 16'h003F);
      wr(`OFS_CTRL, 2'b11, 16'h1F08);
      rdchk(`OFS_LATCH, 16'h0003);
      @(posedge clk);
      stall <= 1'b0;
      repeat (20) @(posedge clk);
      check({8'h00, nBytes}, 16'h0002);
      $display("test flush done");
      summarize();
   end
endmodule

`default_nettype wire
